// File: logic/dctr_top.sv
// Three-channel 16-bit down counter with byte-wide host port.
// Summary of operation
// - Three identical independent 16-bit down counters.
// - Sixteen-bit values move as two byte accesses.
// - Single-byte load clears the other count byte.
// - Enable high counts, enable low suspends counting, except in modes one and five.
// - Six modes, zero to five, are supported.
// - Mode zero: control write drives output low.
// - Mode zero: new count loads next clock.
// - Mode zero: low n clocks, then high.
// - Mode one: count write sets output high, arms.
// - Mode one: enable edge loads, output low.
// - Mode one: trigger stays armed until reprogrammed.
// - Mode one: early retrigger reloads, stays low.
// - Mode one: new count waits for trigger.
// - Mode two: output high, counts after load.
// - Mode two: divide by n, one-clock low pulse.
// - Modes two, three: enable low forces high.
// - Modes two, three: new count at reload.
// - Mode three: output high, starts after load.
// - Mode three: square wave, divide by n.
// - Mode three: count by two, odd waits.
// - Mode three: low half ends, reload, restart.
`timescale 1ns/1ps
module dctr_top (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic nrst_i,
    // Host byte-wide I/O port.
    input wire logic [1:0] bus_addr_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    input wire logic [7:0] bus_wdata_i,
    output logic [7:0] bus_rdata_o,
    // Counter pins.
    input wire logic cnt_clk_i,
    input wire logic [2:0] gate_i,
    output logic [2:0] cnt_out_o,
    output logic tick_interrupt_line_o
);

    ////////////////////////////////////////////////////////////////////////
    // Helper functions.

    // Picks the high or low byte of a count.
    function automatic logic [7:0] pick_byte(input logic [15:0] v,
                                             input logic hi);
        pick_byte = hi ? v[15:8] : v[7:0];
    endfunction : pick_byte

    // Rounds a count down to even for the square wave.
    function automatic logic [15:0] even_cnt(input logic [15:0] v);
        even_cnt = {v[15:1], 1'b0};
    endfunction : even_cnt

    // Folds the two alias codes onto modes two and three.
    function automatic logic [2:0] norm_mode(input logic [2:0] m);
        norm_mode = m[1] ? {1'b0, m[1:0]} : m;
    endfunction : norm_mode

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and count clock edge.

    logic [3:0] sync_w;
    logic clk_d_r;
    logic tick;
    logic [2:0] gate_s;
    logic [7:0] byte_w [dctr_pkg::NUM_CH];
    logic [2:0] out_w;

    // Count clock and enables are asynchronous pins.
    dctr_sync #(
        .WIDTH(4)
    ) u_sync (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .async_i({gate_i, cnt_clk_i}),
        .sync_o(sync_w)
    );

    // Remembers the count clock level for edge detection.
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
        begin
            clk_d_r <= 1'b0;
        end
        else
        begin
            clk_d_r <= sync_w[0];
        end
    end

    // One master cycle per rising count clock edge.
    assign tick = sync_w[0] & ~clk_d_r;
    assign gate_s = sync_w[3:1];

    ////////////////////////////////////////////////////////////////////////
    // Host read data register.

    // Returns the selected byte; the control port reads as zero.
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
        begin
            bus_rdata_o <= dctr_pkg::RST_RDATA;
        end
        else if (bus_rd_i)
        begin
            if (bus_addr_i == dctr_pkg::PORT_CH0)
            begin
                bus_rdata_o <= byte_w[0];
            end
            else if (bus_addr_i == dctr_pkg::PORT_CH1)
            begin
                bus_rdata_o <= byte_w[1];
            end
            else if (bus_addr_i == dctr_pkg::PORT_CH2)
            begin
                bus_rdata_o <= byte_w[2];
            end
            else
            begin
                bus_rdata_o <= dctr_pkg::CTRL_RDATA;
            end
        end
    end

    assign cnt_out_o = out_w;
    assign tick_interrupt_line_o = out_w[0];

    ////////////////////////////////////////////////////////////////////////
    // Counter channels.

    for (genvar ch = 0; ch < dctr_pkg::NUM_CH; ch++)
    begin : g_ch
        logic [2:0] mode_r;
        logic [1:0] acc_r;
        logic [15:0] cr_r;
        logic [15:0] ce_r;
        logic [15:0] ol_r;
        logic out_r;
        logic wr_hi_r;
        logic rd_hi_r;
        logic latched_r;
        logic pend_r;
        logic armed_r;
        logic trig_r;
        logic run_r;
        logic done_r;
        logic low_ph_r;
        logic ext_r;
        logic gate_d_r;
        logic gate;
        logic cw_sel;
        logic cw_hit;
        logic cw_latch;
        logic cnt_wr;
        logic cnt_done;
        logic cnt_rd;
        logic rd_hi;

        // Decodes host accesses aimed at this channel.
        assign gate = gate_s[ch];
        assign cw_sel = bus_wr_i && (bus_addr_i == dctr_pkg::PORT_CTRL) &&
            (bus_wdata_i[dctr_pkg::CW_SEL_HI:dctr_pkg::CW_SEL_LO] == 2'(ch));
        assign cw_latch = cw_sel && (bus_wdata_i[dctr_pkg::CW_ACC_HI:
            dctr_pkg::CW_ACC_LO] == dctr_pkg::ACC_LATCH);
        assign cw_hit = cw_sel && !cw_latch;
        assign cnt_wr = bus_wr_i && (bus_addr_i == 2'(ch));
        assign cnt_rd = bus_rd_i && (bus_addr_i == 2'(ch));
        assign cnt_done = cnt_wr &&
            ((acc_r != dctr_pkg::ACC_WORD) || wr_hi_r);

        // control word sets mode and access
        always_ff @(posedge mclk_i)
        begin
            if (!nrst_i)
            begin
                mode_r <= dctr_pkg::RST_MODE;
                acc_r <= dctr_pkg::RST_ACC;
            end
            else if (cw_hit)
            begin
                mode_r <= norm_mode(bus_wdata_i[dctr_pkg::CW_MODE_HI:
                    dctr_pkg::CW_MODE_LO]);
                acc_r <= bus_wdata_i[dctr_pkg::CW_ACC_HI:dctr_pkg::CW_ACC_LO];
            end
        end

        // Count register loaded a byte at a time.
        always_ff @(posedge mclk_i)
        begin
            if (!nrst_i)
            begin
                cr_r <= dctr_pkg::RST_COUNT;
                wr_hi_r <= 1'b0;
            end
            else if (cw_hit)
            begin
                wr_hi_r <= 1'b0;
            end
            else if (cnt_wr)
            begin
                if (acc_r == dctr_pkg::ACC_LSB)
                begin
                    cr_r <= {8'h00, bus_wdata_i};
                end
                else if (acc_r == dctr_pkg::ACC_MSB)
                begin
                    cr_r <= {bus_wdata_i, 8'h00};
                end
                else if (wr_hi_r)
                begin
                    cr_r[15:8] <= bus_wdata_i;
                    wr_hi_r <= 1'b0;
                end
                else
                begin
                    cr_r[7:0] <= bus_wdata_i;
                    wr_hi_r <= 1'b1;
                end
            end
        end

        // Output latch, latch command and read byte order.
        always_ff @(posedge mclk_i)
        begin
            if (!nrst_i)
            begin
                ol_r <= dctr_pkg::RST_COUNT;
                latched_r <= 1'b0;
                rd_hi_r <= 1'b0;
            end
            else if (cw_hit)
            begin
                latched_r <= 1'b0;
                rd_hi_r <= 1'b0;
            end
            else if (cw_latch && !latched_r)
            begin
                ol_r <= ce_r;
                latched_r <= 1'b1;
            end
            else if (cnt_rd)
            begin
                if (acc_r == dctr_pkg::ACC_WORD)
                begin
                    rd_hi_r <= !rd_hi_r;
                end
                if ((acc_r != dctr_pkg::ACC_WORD) || rd_hi_r)
                begin
                    latched_r <= 1'b0;
                end
            end
        end

        assign rd_hi = (acc_r == dctr_pkg::ACC_MSB) ||
            ((acc_r == dctr_pkg::ACC_WORD) && rd_hi_r);
        assign byte_w[ch] = pick_byte(latched_r ? ol_r : ce_r, rd_hi);

        // enable edge triggers each counter from its own gate
        always_ff @(posedge mclk_i)
        begin
            if (!nrst_i)
            begin
                gate_d_r <= 1'b0;
                trig_r <= 1'b0;
                armed_r <= 1'b0;
            end
            else
            begin
                gate_d_r <= gate;
                // A new edge wins over consumption in the same cycle.
                if (gate && !gate_d_r)
                begin
                    trig_r <= 1'b1;
                end
                else if (tick || cw_hit)
                begin
                    trig_r <= 1'b0;
                end
                if (cw_hit)
                begin
                    armed_r <= 1'b0;
                end
                else if (cnt_done && ((mode_r == dctr_pkg::MODE_ONESHOT) ||
                         (mode_r == dctr_pkg::MODE_HWSTB)))
                begin
                    armed_r <= 1'b1;
                end
            end
        end

        // Counting element and output waveform.
        always_ff @(posedge mclk_i)
        begin
            if (!nrst_i)
            begin
                ce_r <= dctr_pkg::RST_COUNT;
                out_r <= dctr_pkg::RST_OUT;
                pend_r <= 1'b0;
                run_r <= 1'b0;
                done_r <= 1'b0;
                low_ph_r <= 1'b0;
                ext_r <= 1'b0;
            end
            else if (cw_hit)
            begin
                // mode zero output low, others high
                out_r <= (bus_wdata_i[dctr_pkg::CW_MODE_HI:
                    dctr_pkg::CW_MODE_LO] != dctr_pkg::MODE_TC);
                run_r <= 1'b0;
                pend_r <= 1'b0;
                done_r <= 1'b0;
                low_ph_r <= 1'b0;
                ext_r <= 1'b0;
            end
            else
            begin
                // count takes effect on next clock in modes zero and four, and in modes two and three before the first load
                if (cnt_done && ((mode_r == dctr_pkg::MODE_TC) ||
                    (mode_r == dctr_pkg::MODE_SWSTB) || !run_r))
                begin
                    pend_r <= 1'b1;
                end
                // writing a count restarts the low phase
                if (cnt_done && (mode_r == dctr_pkg::MODE_TC))
                begin
                    out_r <= 1'b0;
                end
                if (cnt_done && (mode_r == dctr_pkg::MODE_ONESHOT))
                begin
                    out_r <= 1'b1;
                end
                if (tick)
                begin
                    case (mode_r)
                        dctr_pkg::MODE_TC,
                        dctr_pkg::MODE_SWSTB:
                        begin
                            if (pend_r)
                            begin
                                ce_r <= cr_r;
                                pend_r <= cnt_done; // Keep a new count.
                                run_r <= 1'b1;
                                done_r <= 1'b0;
                            end
                            else if (run_r && gate)
                            begin
                                ce_r <= ce_r - dctr_pkg::STEP_ONE;
                                // once the count hits zero, mode zero goes high, mode four low
                                if ((ce_r == dctr_pkg::STEP_ONE) && !done_r)
                                begin
                                    out_r <= (mode_r == dctr_pkg::MODE_TC) &&
                                        !cnt_done;
                                    done_r <= 1'b1;
                                end
                                else if (mode_r == dctr_pkg::MODE_SWSTB)
                                begin
                                    out_r <= 1'b1;
                                end
                            end
                        end
                        dctr_pkg::MODE_ONESHOT,
                        dctr_pkg::MODE_HWSTB:
                        begin
                            if (trig_r && armed_r)
                            begin
                                ce_r <= cr_r;
                                run_r <= 1'b1;
                                done_r <= 1'b0;
                                out_r <= (mode_r == dctr_pkg::MODE_HWSTB);
                            end
                            else if (run_r)
                            begin
                                ce_r <= ce_r - dctr_pkg::STEP_ONE;
                                if ((ce_r == dctr_pkg::STEP_ONE) && !done_r)
                                begin
                                    out_r <= (mode_r ==
                                        dctr_pkg::MODE_ONESHOT);
                                    done_r <= 1'b1;
                                end
                                else if (mode_r == dctr_pkg::MODE_HWSTB)
                                begin
                                    out_r <= 1'b1;
                                end
                            end
                        end
                        dctr_pkg::MODE_RATE:
                        begin
                            // first load one clock after count
                            if (gate && (trig_r || (pend_r && !run_r)))
                            begin
                                ce_r <= cr_r;
                                run_r <= 1'b1;
                                pend_r <= 1'b0;
                                out_r <= 1'b1;
                            end
                            // one-clock low pulse at count one
                            else if (gate && run_r)
                            begin
                                if (ce_r == dctr_pkg::STEP_TWO)
                                begin
                                    ce_r <= dctr_pkg::STEP_ONE;
                                    out_r <= 1'b0;
                                end
                                else if (ce_r == dctr_pkg::STEP_ONE)
                                begin
                                    ce_r <= cr_r;
                                    out_r <= 1'b1;
                                end
                                else
                                begin
                                    ce_r <= ce_r - dctr_pkg::STEP_ONE;
                                end
                            end
                        end
                        dctr_pkg::MODE_SQUARE:
                        begin
                            // first load one clock after count
                            if (gate && (trig_r || (pend_r && !run_r)))
                            begin
                                ce_r <= even_cnt(cr_r);
                                run_r <= 1'b1;
                                pend_r <= 1'b0;
                                out_r <= 1'b1;
                                low_ph_r <= 1'b0;
                                ext_r <= 1'b0;
                            end
                            else if (gate && run_r)
                            begin
                                // odd count holds high one more
                                if (ext_r)
                                begin
                                    ext_r <= 1'b0;
                                    out_r <= 1'b0;
                                    low_ph_r <= 1'b1;
                                    ce_r <= even_cnt(cr_r);
                                end
                                else if (ce_r == dctr_pkg::STEP_TWO)
                                begin
                                    if (!low_ph_r && cr_r[0])
                                    begin
                                        ext_r <= 1'b1;
                                        ce_r <= ce_r - dctr_pkg::STEP_TWO;
                                    end
                                    else
                                    begin
                                        out_r <= low_ph_r;
                                        low_ph_r <= !low_ph_r;
                                        ce_r <= even_cnt(cr_r);
                                    end
                                end
                                else
                                begin
                                    ce_r <= ce_r - dctr_pkg::STEP_TWO;
                                end
                            end
                        end
                        default:
                        begin
                            run_r <= 1'b0;
                        end
                    endcase
                end
                if (!gate && ((mode_r == dctr_pkg::MODE_RATE) ||
                    (mode_r == dctr_pkg::MODE_SQUARE)))
                begin
                    out_r <= 1'b1;
                    low_ph_r <= 1'b0;
                    ext_r <= 1'b0;
                end
            end
        end

        assign out_w[ch] = out_r;
    end

endmodule : dctr_top

// File: logic/dctr_pkg.sv
// Constants shared by the three-channel down counter block.
package dctr_pkg;

    // Structure of the block.
    localparam int NUM_CH = 3;
    localparam int CNT_W = 16;
    localparam int BYTE_W = 8;
    localparam int SYNC_STAGES = 2;

    // Host port addresses on the byte-wide I/O bus.
    localparam logic [1:0] PORT_CH0 = 2'h0;
    localparam logic [1:0] PORT_CH1 = 2'h1;
    localparam logic [1:0] PORT_CH2 = 2'h2;
    localparam logic [1:0] PORT_CTRL = 2'h3;

    // Control word field positions.
    localparam int CW_SEL_HI = 7;
    localparam int CW_SEL_LO = 6;
    localparam int CW_ACC_HI = 5;
    localparam int CW_ACC_LO = 4;
    localparam int CW_MODE_HI = 3;
    localparam int CW_MODE_LO = 1;

    // Byte access options carried in the control word.
    localparam logic [1:0] ACC_LATCH = 2'h0;
    localparam logic [1:0] ACC_LSB = 2'h1;
    localparam logic [1:0] ACC_MSB = 2'h2;
    localparam logic [1:0] ACC_WORD = 2'h3;

    // Operating modes.
    localparam logic [2:0] MODE_TC = 3'h0;
    localparam logic [2:0] MODE_ONESHOT = 3'h1;
    localparam logic [2:0] MODE_RATE = 3'h2;
    localparam logic [2:0] MODE_SQUARE = 3'h3;
    localparam logic [2:0] MODE_SWSTB = 3'h4;
    localparam logic [2:0] MODE_HWSTB = 3'h5;

    // Reset values, and the value the control port reads.
    localparam logic [2:0] RST_MODE = 3'h0;
    localparam logic [1:0] RST_ACC = 2'h3;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic RST_OUT = 1'b0;
    localparam logic [7:0] RST_RDATA = 8'h00;
    localparam logic [7:0] CTRL_RDATA = 8'h00;

    // Count element steps.
    localparam logic [15:0] STEP_ONE = 16'h0001;
    localparam logic [15:0] STEP_TWO = 16'h0002;

endpackage : dctr_pkg

// File: logic/dctr_sync.sv
// Two-stage synchroniser for pins entering the master clock domain.
`timescale 1ns/1ps
module dctr_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic nrst_i,
    // Asynchronous inputs and their synchronised copies.
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_r;

    // Refuse a width the flops cannot serve.
    if (WIDTH < 1)
    begin : g_bad_width
        $error("dctr_sync needs WIDTH of at least one");
    end

    // First stage feeds only the second stage.
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
        begin
            meta_r <= '0;
            sync_o <= '0;
        end
        else
        begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end

endmodule : dctr_sync

// File: testbench/dctr_chk_sva.sv
// Port checker for the three-channel down counter.
`timescale 1ns/1ps
module dctr_chk (
    // Watched ports.
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [1:0] bus_addr_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    input wire logic [7:0] bus_wdata_i,
    input wire logic [7:0] bus_rdata_o,
    input wire logic cnt_clk_i,
    input wire logic [2:0] gate_i,
    input wire logic [2:0] cnt_out_o,
    input wire logic tick_interrupt_line_o
);
    logic clk_d_r;
    logic [3:0] since_r;
    logic m23_r;
    wire cw = bus_wr_i && bus_addr_i == 2'h3 && bus_wdata_i[5:4] != 2'h0;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    // Cycles since a count clock rise, and mode class of counter two.
    always_ff @(posedge mclk_i)
    begin
        clk_d_r <= cnt_clk_i;
        if (cnt_clk_i && !clk_d_r) since_r <= 4'h0;
        else if (since_r != 4'hF) since_r <= since_r + 4'h1;
        if (!nrst_i) m23_r <= 1'b0;
        else if (cw && bus_wdata_i[7:6] == 2'h2) m23_r <= bus_wdata_i[2];
    end
    sequence s_ctrl(logic [1:0] ch);
        cw && bus_wdata_i[7:6] == ch;
    endsequence
    sequence s_gate_low;
        m23_r && !gate_i[2] && !bus_wr_i;
    endsequence
    property p_rst;
        disable iff (1'b0) !nrst_i |=> cnt_out_o == 3'h0 && bus_rdata_o == 8'h00;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle in reset");
    property p_copy;
        $changed(tick_interrupt_line_o) |-> since_r == 4'h2 || $past(bus_wr_i);
    endproperty
    a_copy: assert property (p_copy) else $error("tick line off tick");
    property p_rd_hold;
        !bus_rd_i |=> $stable(bus_rdata_o);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_ctrl_rd;
        bus_rd_i && bus_addr_i == 2'h3 |=> bus_rdata_o == 8'h00;
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("control read");
    property p_m0_low;
        s_ctrl(2'h0) ##0 bus_wdata_i[3:1] == 3'h0 |-> ##2 !cnt_out_o[0];
    endproperty
    a_m0_low: assert property (p_m0_low) else $error("mode 0 not low");
    property p_m23_high;
        s_ctrl(2'h2) ##0 bus_wdata_i[2] |-> ##2 cnt_out_o[2];
    endproperty
    a_m23_high: assert property (p_m23_high) else $error("not high");
    property p_gate;
        s_gate_low[*4] |=> cnt_out_o[2];
    endproperty
    a_gate: assert property (p_gate) else $error("gate low, out low");
    property p_fall;
        $fell(cnt_out_o[1]) && !$past(bus_wr_i) && !$past(bus_wr_i, 2)
            |-> since_r inside {[4'h1:4'h6]};
    endproperty
    a_fall: assert property (p_fall) else $error("fall off tick");
endmodule : dctr_chk
bind dctr_top dctr_chk u_chk (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .bus_addr_i(bus_addr_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
    .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o),
    .cnt_clk_i(cnt_clk_i), .gate_i(gate_i), .cnt_out_o(cnt_out_o),
    .tick_interrupt_line_o(tick_interrupt_line_o));

// File: testbench/dctr_pins.sv
// Count clock source and gate wiring around the counter block.
`timescale 1ns/1ps
module dctr_pins #(
    parameter int HALF = 10
) (
    input wire logic mclk_i,
    input wire logic gate2_i,
    output logic cnt_clk_o,
    output logic [2:0] gate_o
);
    int n = 0;
    // Free-running count clock, 2 * HALF master cycles a period.
    always_ff @(posedge mclk_i)
        n <= (n == 2 * HALF - 1) ? 0 : n + 1;
    assign cnt_clk_o = n >= HALF;
    assign gate_o = {gate2_i, 2'b11};
endmodule : dctr_pins

// File: testbench/dctr_top_bench.sv
// Self-checking bench for the three-channel down counter.
`timescale 1ns/1ps
module dctr_top_bench;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [1:0] bus_addr_i = 2'h0;
    logic bus_wr_i = 1'b0;
    logic bus_rd_i = 1'b0;
    logic [7:0] bus_wdata_i = 8'h00;
    logic [7:0] bus_rdata_o;
    logic cnt_clk_i;
    logic gate2 = 1'b0;
    logic [2:0] gate_i;
    logic [2:0] cnt_out_o;
    logic tick_o;
    int bad_count = 0;
    int n_compared = 0;
    int ones;
    dctr_pins u_pins (.mclk_i(mclk_i), .gate2_i(gate2),
        .cnt_clk_o(cnt_clk_i), .gate_o(gate_i));
    dctr_top u_dut (.mclk_i(mclk_i), .nrst_i(nrst_i),
        .bus_addr_i(bus_addr_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
        .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o),
        .cnt_clk_i(cnt_clk_i), .gate_i(gate_i), .cnt_out_o(cnt_out_o),
        .tick_interrupt_line_o(tick_o));
    // Master clock.
    initial forever #2.5 mclk_i = !mclk_i;
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask : chk
    task wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        bus_addr_i <= a;
        bus_wdata_i <= d;
        bus_wr_i <= 1'b1;
        @(posedge mclk_i);
        bus_wr_i <= 1'b0;
    endtask : wr
    task rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        bus_addr_i <= a;
        bus_rd_i <= 1'b1;
        @(posedge mclk_i);
        bus_rd_i <= 1'b0;
        @(negedge mclk_i);
        chk(bus_rdata_o, exp);
    endtask : rd
    // Wait n count clock rises, then let the outputs settle.
    task tk(input int n);
        repeat (n) @(posedge cnt_clk_i);
        repeat (6) @(posedge mclk_i);
        @(negedge mclk_i);
    endtask : tk
    // A short low pulse on the counter two gate, ending in a rise.
    task trig;
        @(posedge mclk_i);
        gate2 <= 1'b0;
        repeat (4) @(posedge mclk_i);
        gate2 <= 1'b1;
    endtask : trig
    task test_done;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    // Watchdog.
    initial
    begin
        repeat (20000) @(posedge mclk_i);
        bad_count++;
        test_done();
    end
    // Test sequence.
    initial
    begin
        repeat (4) @(posedge mclk_i);
        nrst_i <= 1'b1;
        tk(1);
        wr(2'h3, 8'h20);
        wr(2'h0, 8'h01);
        wr(2'h3, 8'h10);
        wr(2'h0, 8'h02);
        tk(2);
        chk(cnt_out_o[0], 1'b0);
        chk(tick_o, 1'b0);
        tk(1);
        chk(cnt_out_o[0], 1'b1);
        chk(tick_o, 1'b1);
        $display("mode 0 test done");
        tk(1);
        wr(2'h3, 8'h74);
        wr(2'h1, 8'h03);
        wr(2'h1, 8'h00);
        tk(1);
        for (int i = 0; i < 6; i++)
        begin
            tk(1);
            chk(cnt_out_o[1], i % 3 != 1);
        end
        $display("mode 2 test done");
        @(posedge mclk_i);
        gate2 <= 1'b1;
        for (int n = 4; n < 6; n++)
        begin
            tk(1);
            wr(2'h3, 8'hB6);
            wr(2'h2, n[7:0]);
            wr(2'h2, 8'h00);
            tk(n + 1);
            ones = 0;
            for (int i = 0; i < 2 * n; i++)
            begin
                tk(1);
                ones += cnt_out_o[2];
            end
            chk(ones[7:0], n + n % 2);
        end
        $display("mode 3 test done");
        @(posedge mclk_i);
        gate2 <= 1'b0;
        tk(2);
        chk(cnt_out_o[2], 1'b1);
        wr(2'h3, 8'hB0);
        wr(2'h2, 8'h34);
        wr(2'h2, 8'h12);
        tk(3);
        chk(cnt_out_o[2], 1'b0);
        wr(2'h3, 8'h80);
        rd(2'h2, 8'h34);
        rd(2'h2, 8'h12);
        rd(2'h3, 8'h00);
        $display("gate and readback test done");
        tk(1);
        wr(2'h3, 8'hB2);
        wr(2'h2, 8'h03);
        wr(2'h2, 8'h00);
        tk(1);
        chk(cnt_out_o[2], 1'b1);
        trig();
        tk(2);
        chk(cnt_out_o[2], 1'b0);
        trig();
        tk(3);
        chk(cnt_out_o[2], 1'b0);
        tk(1);
        chk(cnt_out_o[2], 1'b1);
        trig();
        tk(1);
        chk(cnt_out_o[2], 1'b0);
        $display("mode 1 test done");
        tk(1);
        wr(2'h3, 8'h18);
        wr(2'h0, 8'h02);
        tk(3);
        chk(tick_o, 1'b0);
        tk(1);
        chk(cnt_out_o[0], 1'b1);
        $display("mode 4 test done");
        test_done();
    end
endmodule : dctr_top_bench
